// ---- design/addr_decode_params.svh ----
// Address map, widths and reset constants of the address space decoder
`ifndef ADDR_DECODE_PARAMS_SVH
`define ADDR_DECODE_PARAMS_SVH

// Widths
`define ADDR_W 24
`define EXT_ADDR_W 20
`define OFS_W 16
`define TGT_W 4
`define NUM_TGT 9
`define SYNC_W 1

// Reset fetch address and strap settling
`define RESET_VECTOR 24'hff2080
`define SYNC_FILL 2'h2

// Upper bank marker byte
`define HI_BANK_BYTE 8'hff

// Code fetches forced external in this range
`define FORCE_EXT_LO 24'h000000
`define FORCE_EXT_HI 24'h0003ff

// Register file and CPU special registers
`define CPU_SFR_LO 24'h000000
`define CPU_SFR_HI 24'h000017
`define LOWER_RF_LO 24'h000018
`define LOWER_RF_HI 24'h0000ff
`define UPPER_RF_LO 24'h000100
`define UPPER_RF_HI 24'h0003ff

// Internal RAM and its upper-bank mirror
`define IRAM_LO 24'h000400
`define IRAM_HI 24'h0005ff
`define IRAM_MIR_LO 24'hff0400
`define IRAM_MIR_HI 24'hff05ff

// Special function registers
`define SFR_INT_LO 24'h001f00
`define SFR_INT_HI 24'h001fdf
`define SFR_MM_LO 24'h001fe0
`define SFR_MM_HI 24'h001fff

// Program memory windows, reserved part first
`define OTP_LOW_LO 24'h002000
`define OTP_LOW_RES_HI 24'h00207f
`define OTP_LOW_HI 24'h009fff
`define OTP_HIGH_LO 24'hff2000
`define OTP_HIGH_RES_HI 24'hff207f
`define OTP_HIGH_HI 24'hff9fff
`define OTP_BASE16 16'h2000

// Target-local offset widths
`define RF_OFS_W 10
`define IRAM_OFS_W 9
`define SFR_OFS_W 8
`define OTP_OFS_W 15

// Emulator reserved window
`define ICE_LO 24'hff0000
`define ICE_HI 24'hff00ff

// External ranges named for reference
`define EXT_LOW_LO 24'h00a000
`define EXT_LOW_HI 24'h0fffff
`define EXT_FUTURE_LO 24'h100000
`define EXT_FUTURE_HI 24'hfeffff

`endif

// ---- design/addr_decode_pkg.sv ----
// Types shared by the address space decoder files
package addr_decode_pkg;
  `include "addr_decode_params.svh"

  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`EXT_ADDR_W-1:0] ext_addr_t;
  typedef logic [`OFS_W-1:0] offset_t;

  // Decode targets
  typedef enum logic [`TGT_W-1:0] {
    TGT_CPU_SFR  = 4'b0000,
    TGT_LOWER_RF = 4'b0001,
    TGT_UPPER_RF = 4'b0010,
    TGT_IRAM     = 4'b0011,
    TGT_SFR_INT  = 4'b0100,
    TGT_SFR_MM   = 4'b0101,
    TGT_OTP      = 4'b0110,
    TGT_EXT      = 4'b0111,
    TGT_ICE      = 4'b1000
  } target_t;

  // Reset sequencing states
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_STRAP  = 2'b01,
    ST_BOOT   = 2'b10,
    ST_RUN    = 2'b11
  } boot_state_t;

  // Access from the core
  typedef struct packed {
    logic fetch;
    logic write;
    addr_t addr;
  } core_req_t;

  // Decoded access
  typedef struct packed {
    target_t target;
    logic reserved;
    logic fetch;
    logic write;
    offset_t offset;
    ext_addr_t ext_addr;
  } decode_t;
endpackage

// ---- design/bit_sync.sv ----
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage is read only by the second stage
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// ---- design/addr_space_decoder.sv ----
// Address space decoder steering core accesses to internal targets or the external bus
//
// Contract
// - Upper bank FF2080H..FF9FFFH is program memory or external per pin; boot fetches FF2080H.
// - FF0400H..FF05FFH reach the same internal RAM cells as 000400H..0005FFH.
// - Low program area is internal only with program_memory_bit_a bit set and pin high.
// - Instruction fetches from 00000H..003FFH always go to the external bus.
// - Internal address is 24 bits; only low 20 bits drive the bus.
// - 001FE0H..001FFFH select the memory-mapped special function registers.
// - 001F00H..001FDFH select the internal special function registers.
// - 000000H..000017H select CPU registers; 000018H..0000FFH the lower register file.
// - 000100H..0003FFH select the upper register file.
// - 00A000H up to the one-megabyte top goes to external memory.
// - 100000H..FEFFFFH decode as external memory reserved for future parts.
`timescale 1ns/1ns
`include "addr_decode_params.svh"
module addr_space_decoder (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Core request
  input wire logic req_valid_i,
  input wire addr_decode_pkg::core_req_t req_i,
  output logic req_ready_o,
  // Straps and configuration
  input wire logic external_access_select_i,
  input wire logic config_byte_two_bit_two_i,
  // Decoded access
  output logic dec_valid_o,
  output addr_decode_pkg::decode_t dec_o,
  output logic [`NUM_TGT-1:0] sel_o,
  output logic boot_o,
  // External bus start
  output logic ext_start_o,
  output logic [`EXT_ADDR_W-1:0] ext_addr_o,
  // Latched program memory enables
  output logic otp_low_en_o,
  output logic otp_high_en_o
);
  import addr_decode_pkg::*;

  // Range test used across the map
  function automatic logic in_rng(input addr_t a, input addr_t lo, input addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Reserved head of either program memory window
  function automatic logic is_reserved(input addr_t a);
    return in_rng(a, `OTP_LOW_LO, `OTP_LOW_RES_HI) || in_rng(a, `OTP_HIGH_LO, `OTP_HIGH_RES_HI);
  endfunction

  // Target decode with fetch forcing and program memory enables
  function automatic target_t decode_target(input addr_t a, input logic fetch,
                                            input logic otp_low, input logic otp_high);
    target_t t;
    t = TGT_EXT;
    if (fetch && in_rng(a, `FORCE_EXT_LO, `FORCE_EXT_HI)) begin
      t = TGT_EXT;
    end else if (in_rng(a, `CPU_SFR_LO, `CPU_SFR_HI)) begin
      t = TGT_CPU_SFR;
    end else if (in_rng(a, `LOWER_RF_LO, `LOWER_RF_HI)) begin
      t = TGT_LOWER_RF;
    end else if (in_rng(a, `UPPER_RF_LO, `UPPER_RF_HI)) begin
      t = TGT_UPPER_RF;
    end else if (in_rng(a, `IRAM_LO, `IRAM_HI) || in_rng(a, `IRAM_MIR_LO, `IRAM_MIR_HI)) begin
      t = TGT_IRAM;
    end else if (in_rng(a, `SFR_INT_LO, `SFR_INT_HI)) begin
      t = TGT_SFR_INT;
    end else if (in_rng(a, `SFR_MM_LO, `SFR_MM_HI)) begin
      t = TGT_SFR_MM;
    end else if (in_rng(a, `OTP_LOW_LO, `OTP_LOW_HI)) begin
      t = otp_low ? TGT_OTP : TGT_EXT;
    end else if (in_rng(a, `OTP_HIGH_LO, `OTP_HIGH_HI)) begin
      t = otp_high ? TGT_OTP : TGT_EXT;
    end else if (in_rng(a, `ICE_LO, `ICE_HI)) begin
      t = TGT_ICE;
    end else if (in_rng(a, `EXT_LOW_LO, `EXT_LOW_HI)) begin
      t = TGT_EXT;
    end else if (in_rng(a, `EXT_FUTURE_LO, `EXT_FUTURE_HI)) begin
      t = TGT_EXT;
    end else begin
      t = TGT_EXT;
    end
    return t;
  endfunction

  // Target-local offset of an access
  function automatic offset_t local_offset(input addr_t a, input target_t t);
    offset_t o;
    logic [`OFS_W-1:0] otp_rel;
    o = '0;
    otp_rel = a[`OFS_W-1:0] - `OTP_BASE16;
    case (t)
      TGT_CPU_SFR, TGT_LOWER_RF, TGT_UPPER_RF: begin
        o = offset_t'(a[`RF_OFS_W-1:0]);
      end
      TGT_IRAM: begin
        o = offset_t'(a[`IRAM_OFS_W-1:0]);
      end
      TGT_SFR_INT, TGT_SFR_MM, TGT_ICE: begin
        o = offset_t'(a[`SFR_OFS_W-1:0]);
      end
      TGT_OTP: begin
        o = offset_t'(otp_rel[`OTP_OFS_W-1:0]);
      end
      default: begin
        o = '0;
      end
    endcase
    return o;
  endfunction

  // State and registered outputs
  boot_state_t state_r;
  boot_state_t state_nxt;
  logic [1:0] settle_cnt_r;
  logic [1:0] settle_cnt_nxt;
  logic ea_high_r;
  logic program_memory_bit_a_r;
  decode_t dec_r;
  decode_t dec_nxt;
  logic dec_valid_r;
  logic dec_valid_nxt;
  logic boot_r;
  logic boot_nxt;
  logic ext_start_r;
  logic ext_start_nxt;
  logic [`SYNC_W-1:0] ea_sync;

  // Pin level through two flip-flops before use
  bit_sync #(
    .W(`SYNC_W)
  ) u_ea_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(external_access_select_i),
    .sync_o(ea_sync)
  );

  // Selected access: boot fetch or core request
  wire logic take_req = req_valid_i && (state_r == ST_RUN);
  wire logic boot_cycle = (state_r == ST_BOOT);
  wire addr_t acc_addr = boot_cycle ? `RESET_VECTOR : req_i.addr;
  wire logic acc_fetch = boot_cycle ? 1'b1 : req_i.fetch;
  wire logic acc_write = boot_cycle ? 1'b0 : req_i.write;
  wire logic acc_valid = take_req || boot_cycle;

  // Program memory enables from latched straps
  wire logic otp_high_en = ea_high_r;
  wire logic otp_low_en = ea_high_r && program_memory_bit_a_r;

  // Decode of the selected access
  wire target_t acc_target = decode_target(acc_addr, acc_fetch, otp_low_en, otp_high_en);
  wire offset_t acc_offset = local_offset(acc_addr, acc_target);
  wire logic acc_reserved = is_reserved(acc_addr);

  // Reset sequencing: settle sync, latch straps, issue boot fetch
  always_comb begin
    state_nxt = state_r;
    settle_cnt_nxt = settle_cnt_r;
    case (state_r)
      ST_SETTLE: begin
        if (settle_cnt_r == `SYNC_FILL) begin
          state_nxt = ST_STRAP;
        end else begin
          settle_cnt_nxt = settle_cnt_r + 2'h1;
        end
      end
      ST_STRAP: begin
        state_nxt = ST_BOOT;
      end
      ST_BOOT: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_SETTLE;
      end
    endcase
  end

  // Next decoded access
  always_comb begin
    dec_nxt = dec_r;
    dec_valid_nxt = acc_valid;
    boot_nxt = boot_cycle;
    ext_start_nxt = acc_valid && (acc_target == TGT_EXT);
    if (acc_valid) begin
      dec_nxt.target = acc_target;
      dec_nxt.reserved = acc_reserved;
      dec_nxt.fetch = acc_fetch;
      dec_nxt.write = acc_write;
      dec_nxt.offset = acc_offset;
      dec_nxt.ext_addr = acc_addr[`EXT_ADDR_W-1:0];
    end
  end

  // Sequencer and strap latches
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_SETTLE;
      settle_cnt_r <= 2'h0;
      ea_high_r <= 1'b0;
      program_memory_bit_a_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      if (state_r == ST_STRAP) begin
        ea_high_r <= ea_sync[0];
        program_memory_bit_a_r <= config_byte_two_bit_two_i;
      end
    end
  end

  // Decode output registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dec_r <= '0;
      dec_valid_r <= 1'b0;
      boot_r <= 1'b0;
      ext_start_r <= 1'b0;
    end else begin
      dec_r <= dec_nxt;
      dec_valid_r <= dec_valid_nxt;
      boot_r <= boot_nxt;
      ext_start_r <= ext_start_nxt;
    end
  end

  // One-hot target selects
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_TGT; gi++) begin : g_sel
      assign sel_o[gi] = dec_valid_r && (dec_r.target == target_t'(gi));
    end
  endgenerate

  // Output drive
  assign req_ready_o = (state_r == ST_RUN);
  assign dec_valid_o = dec_valid_r;
  assign dec_o = dec_r;
  assign boot_o = boot_r;
  assign ext_start_o = ext_start_r;
  assign ext_addr_o = dec_r.ext_addr;
  assign otp_low_en_o = otp_low_en;
  assign otp_high_en_o = otp_high_en;
endmodule

// ---- tb/addr_decode_checker.sv ----
// Port checker of the address space decoder
`timescale 1ns/1ns
`include "addr_decode_params.svh"
module addr_decode_checker (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Core request
  input wire logic req_valid_i,
  input wire addr_decode_pkg::core_req_t req_i,
  input wire logic req_ready_o,
  // Decoded access and bus start
  input wire logic dec_valid_o,
  input wire addr_decode_pkg::decode_t dec_o,
  input wire logic [`NUM_TGT-1:0] sel_o,
  input wire logic boot_o,
  input wire logic ext_start_o,
  input wire logic [`EXT_ADDR_W-1:0] ext_addr_o,
  input wire logic otp_low_en_o,
  input wire logic otp_high_en_o
);
  import addr_decode_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Address views used by the expectations
  wire addr_t a = req_i.addr;
  wire logic [19:0] a_low = req_i.addr[19:0];
  wire offset_t off9 = {7'h0, req_i.addr[8:0]};
  wire logic mm = req_i.addr[7:5] == 3'h7;
  wire target_t rf_exp = (a <= 24'h000017) ? TGT_CPU_SFR : (a <= 24'h0000ff) ? TGT_LOWER_RF : TGT_UPPER_RF;
  // Accepted data and fetch requests
  sequence took_data;
    req_valid_i && req_ready_o && !req_i.fetch;
  endsequence
  sequence took_fetch;
    req_valid_i && req_ready_o && req_i.fetch;
  endsequence
  sel_one_hot_a: assert property (dec_valid_o |-> $onehot(sel_o) && sel_o[dec_o.target])
    else $error("select not one-hot on decode");
  sel_idle_a: assert property (!dec_valid_o |-> sel_o == '0)
    else $error("select active without decode");
  bus_start_a: assert property (ext_start_o == (dec_valid_o && dec_o.target == TGT_EXT))
    else $error("bus start does not match external target");
  fetch_forced_a: assert property (took_fetch and (a <= 24'h0003ff) |=> dec_valid_o && dec_o.target == TGT_EXT)
    else $error("low fetch not sent external");
  bus_addr_low_a: assert property (req_valid_i && req_ready_o |=> ext_addr_o == $past(a_low))
    else $error("bus address not low bits of request");
  ram_mirror_a: assert property (took_data and (a inside {[24'hff0400:24'hff05ff]})
    |=> dec_o.target == TGT_IRAM && dec_o.offset == $past(off9))
    else $error("mirror not mapped onto internal ram");
  sfr_map_a: assert property (took_data and (a inside {[24'h001f00:24'h001fff]})
    |=> dec_o.target == ($past(mm) ? TGT_SFR_MM : TGT_SFR_INT))
    else $error("register block decoded wrongly");
  reg_file_a: assert property (took_data and (a <= 24'h0003ff) |=> dec_o.target == $past(rf_exp))
    else $error("register file decoded wrongly");
  low_otp_a: assert property (took_data and (a inside {[24'h002000:24'h009fff]})
    |=> dec_o.target == (otp_low_en_o ? TGT_OTP : TGT_EXT))
    else $error("low program area ignores enable");
  far_ext_a: assert property (took_data and (a inside {[24'h00a000:24'hfeffff]}) |=> ext_start_o)
    else $error("far range did not start bus cycle");
  boot_vector_a: assert property (boot_o |-> dec_valid_o && ext_addr_o == 20'hf2080
    && dec_o.target == (otp_high_en_o ? TGT_OTP : TGT_EXT))
    else $error("boot decode wrong");
endmodule
bind addr_space_decoder addr_decode_checker chk (.mclk_i, .rst_n_i, .req_valid_i, .req_i, .req_ready_o,
  .dec_valid_o, .dec_o, .sel_o, .boot_o, .ext_start_o, .ext_addr_o, .otp_low_en_o, .otp_high_en_o);

// ---- tb/ext_bus_model.sv ----
// External bus model counting bus cycles and keeping the last bus address
`timescale 1ns/1ns
module ext_bus_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Bus cycle start from the decoder
  input wire logic ext_start_i,
  input wire logic [19:0] ext_addr_i,
  // Bus activity seen
  output int cycles_o,
  output logic [19:0] addr_o
);
  // Take one bus cycle per start pulse, only 20 lines exist
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cycles_o <= 0;
      addr_o <= 20'h0;
    end else if (ext_start_i) begin
      cycles_o <= cycles_o + 1;
      addr_o <= ext_addr_i;
    end
  end
endmodule

// ---- tb/addr_space_decoder_tb.sv ----
// Self-checking testbench of the address space decoder
`timescale 1ns/1ns
`include "addr_decode_params.svh"
module addr_space_decoder_tb;
  import addr_decode_pkg::*;
  logic mclk_i, rst_n_i, req_valid_i, pin, rmp;
  logic req_ready_o, dec_valid_o, boot_o, ext_start_o, otp_low_en_o, otp_high_en_o;
  core_req_t req_i;
  decode_t dec_o;
  logic [`NUM_TGT-1:0] sel_o;
  logic [19:0] ext_addr_o, bus_addr, last_ext;
  int bus_cycles, exp_bus, bad_count, num_checks;
  addr_t tbl[26] = '{24'h000000, 24'h000017, 24'h000018, 24'h0000ff, 24'h000100, 24'h0003ff, 24'h000400,
    24'h0005ff, 24'h000600, 24'h001f00, 24'h001fdf, 24'h001fe0, 24'h001fff, 24'h002000, 24'h002080,
    24'h009fff, 24'h00a000, 24'h0fffff, 24'h100000, 24'hfeffff, 24'hff0000, 24'hff0400, 24'hff05ff,
    24'hff2080, 24'hff9fff, 24'hffa000};
  addr_space_decoder dut (.mclk_i, .rst_n_i, .req_valid_i, .req_i, .req_ready_o,
    .external_access_select_i(pin), .config_byte_two_bit_two_i(rmp), .dec_valid_o, .dec_o, .sel_o,
    .boot_o, .ext_start_o, .ext_addr_o, .otp_low_en_o, .otp_high_en_o);
  ext_bus_model bus (.mclk_i, .rst_n_i, .ext_start_i(ext_start_o), .ext_addr_i(ext_addr_o),
    .cycles_o(bus_cycles), .addr_o(bus_addr));
  // Clock of 100 ns
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // Compare and count
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Target expected from the address map and straps
  function automatic target_t exp_tgt(logic f, addr_t a);
    if (f && a <= 24'h0003ff) return TGT_EXT;
    if (a <= 24'h000017) return TGT_CPU_SFR;
    if (a <= 24'h0000ff) return TGT_LOWER_RF;
    if (a <= 24'h0003ff) return TGT_UPPER_RF;
    if (a <= 24'h0005ff) return TGT_IRAM;
    if (a inside {[24'h001f00:24'h001fdf]}) return TGT_SFR_INT;
    if (a inside {[24'h001fe0:24'h001fff]}) return TGT_SFR_MM;
    if (a inside {[24'h002000:24'h009fff]}) return (pin && rmp) ? TGT_OTP : TGT_EXT;
    if (a inside {[24'hff0000:24'hff00ff]}) return TGT_ICE;
    if (a inside {[24'hff0400:24'hff05ff]}) return TGT_IRAM;
    if (a inside {[24'hff2000:24'hff9fff]}) return pin ? TGT_OTP : TGT_EXT;
    return TGT_EXT;
  endfunction
  // Offset expected inside the selected target
  function automatic logic [15:0] exp_off(target_t t, addr_t a);
    if (t inside {TGT_CPU_SFR, TGT_LOWER_RF, TGT_UPPER_RF}) return {6'h0, a[9:0]};
    if (t inside {TGT_SFR_INT, TGT_SFR_MM, TGT_ICE}) return {8'h0, a[7:0]};
    if (t == TGT_IRAM) return {7'h0, a[8:0]};
    if (t == TGT_OTP) return {1'b0, a[14:0] - 15'h2000};
    return 16'h0;
  endfunction
  // One request, judged in the cycle after it is taken
  task automatic access(logic f, addr_t a);
    target_t t;
    logic res;
    t = exp_tgt(f, a);
    res = a inside {[24'h002000:24'h00207f], [24'hff2000:24'hff207f]};
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    // Reads only: reserved cells keep their fill, reserved bits are never written
    req_i <= '{fetch: f, write: 1'b0, addr: a};
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    #1;
    chk("decode valid", 24'h1, {23'h0, dec_valid_o});
    chk("target", {20'h0, t}, {20'h0, dec_o.target});
    chk("select", 24'h1 << t, {15'h0, sel_o});
    chk("bus start", {23'h0, t == TGT_EXT}, {23'h0, ext_start_o});
    chk("bus address", {4'h0, a[19:0]}, {4'h0, ext_addr_o});
    if (t == TGT_IRAM) chk("ram offset", {15'h0, a[8:0]}, {8'h0, dec_o.offset});
    chk("offset", {8'h0, exp_off(t, a)}, {8'h0, dec_o.offset});
    chk("reserved flag", {23'h0, res}, {23'h0, dec_o.reserved});
    chk("fetch flag", {23'h0, f}, {23'h0, dec_o.fetch});
    chk("write flag", 24'h0, {23'h0, dec_o.write});
    if (t == TGT_EXT) begin
      exp_bus++;
      last_ext = a[19:0];
    end
  endtask
  // Bus traffic totals at the end of each test
  task automatic end_test(string name);
    @(posedge mclk_i);
    #1;
    chk("bus cycles", exp_bus[23:0], bus_cycles[23:0]);
    chk("last bus address", {4'h0, last_ext}, {4'h0, bus_addr});
    $display("test done: %s", name);
  endtask
  // Reset with given straps and judge the boot decode
  task automatic test_boot(logic p, logic r);
    int n;
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    pin <= p;
    rmp <= r;
    // Request held through reset sequencing must be refused
    req_valid_i <= 1'b1;
    req_i <= '{fetch: 1'b0, write: 1'b0, addr: 24'h00a000};
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    exp_bus = p ? 0 : 1;
    last_ext = p ? 20'h0 : 20'hf2080;
    n = 0;
    while (boot_o !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      if (n == 3) req_valid_i <= 1'b0;
      #1;
      n++;
      if (n == 4) chk("ready in sequencing", 24'h0, {23'h0, req_ready_o});
    end
    chk("boot delay", 24'h5, n[23:0]);
    chk("boot target", p ? 24'h6 : 24'h7, {20'h0, dec_o.target});
    chk("boot address", 24'h0f2080, {4'h0, ext_addr_o});
    chk("ready after boot", 24'h1, {23'h0, req_ready_o});
    chk("low enable", {23'h0, p & r}, {23'h0, otp_low_en_o});
    chk("high enable", {23'h0, p}, {23'h0, otp_high_en_o});
    end_test("boot");
  endtask
  // Data accesses across the whole map
  task automatic test_map();
    foreach (tbl[i]) access(1'b0, tbl[i]);
    end_test("data map");
  endtask
  // Code fetches across the whole map
  task automatic test_fetch();
    foreach (tbl[i]) access(1'b1, tbl[i]);
    end_test("fetch map");
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence over three strap settings
  initial begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    pin = 1'b1;
    rmp = 1'b1;
    bad_count = 0;
    num_checks = 0;
    test_boot(1'b1, 1'b1);
    test_map();
    test_fetch();
    test_boot(1'b1, 1'b0);
    test_map();
    test_boot(1'b0, 1'b1);
    test_map();
    test_fetch();
    wrap_up();
  end
  // Watchdog, about seven times the expected run of some 350 cycles
  initial begin
    #250000;
    bad_count++;
    wrap_up();
  end
endmodule
